// *** design/eedr_ctrl.v ***
// Overview of operation
// - Eight-bit data register, read and write, clears to zero at reset.
// - Mode bit low gives byte reads, high gives page reads.
// - Read start is ignored while read enable is low.
// - Byte read end loads data register and self-clears read start.
// - Data register keeps the read byte until another read or write.
// - Page reads cover at most sixteen bytes from the loaded start.
// - Page read: data first, then address increment, then start clears.
// - Each new read start in page mode fetches the next address, or offset fifteen again.
// - Upper three address bits pick page; only lower four increment.
// - Lower four address bits saturate at fifteen, never wrap or carry.
// - Address register holds seven bits; bit seven reads zero.
// - Erase end clears erase start, then clears erase enable.
// - Write end clears write start so software can poll it.
`timescale 1ns/100ps
`include "eedr_regs.vh"

module eedr_ctrl #(
   parameter [`EEDR_TMR_W-1:0] ER_SHORT_CYC = `EEDR_ER_SHORT_CYC,
   parameter [`EEDR_TMR_W-1:0] ER_LONG_CYC  = `EEDR_ER_LONG_CYC,
   parameter [`EEDR_TMR_W-1:0] WR_SHORT_CYC = `EEDR_WR_SHORT_CYC,
   parameter [`EEDR_TMR_W-1:0] WR_LONG_CYC  = `EEDR_WR_LONG_CYC
) (
   // Clock and reset
   input  wire       i_clk,
   input  wire       i_reset_n,
   // Register writes from the core
   input  wire       i_addr_wr,
   input  wire       i_data_wr,
   input  wire       i_ctrl_wr,
   input  wire [7:0] i_wdata,
   // Register read values
   output wire [7:0] o_addr_q,
   output wire [7:0] o_data_q,
   output wire [7:0] o_ctrl_q,
   // Completion event
   output reg        o_done
);

   // ----------------------------------------------------------------------
   // States
   // ----------------------------------------------------------------------
   localparam [2:0] ST_IDLE   = 3'b000;
   localparam [2:0] ST_RD     = 3'b001;
   localparam [2:0] ST_RD_INC = 3'b010;
   localparam [2:0] ST_RD_CLR = 3'b011;
   localparam [2:0] ST_PROG   = 3'b100;
   localparam [2:0] ST_EN_CLR = 3'b101;

   localparam [`EEDR_TMR_W-1:0] RD_CYC = `EEDR_RD_CYC;
   localparam [`EEDR_TMR_W-1:0] TMR_ONE = 18'h0_0001;

   // ----------------------------------------------------------------------
   // Functions
   // ----------------------------------------------------------------------
   // Offset saturates at the page end; page bits are never touched
   function [6:0] sat_inc;
      input [6:0] a;
      begin
         if (a[3:0] == `EEDR_OFF_MAX) begin
            sat_inc = a;
         end else begin
            sat_inc = {a[6:4], a[3:0] + 4'h1};
         end
      end
   endfunction

   // Timer load for a programming cycle; the long setting trades
   // throughput for margin on a slow array
   function [`EEDR_TMR_W-1:0] cyc_len;
      input is_erase;
      input long_sel;
      begin
         if (is_erase) begin
            cyc_len = long_sel ? ER_LONG_CYC : ER_SHORT_CYC;
         end else begin
            cyc_len = long_sel ? WR_LONG_CYC : WR_SHORT_CYC;
         end
      end
   endfunction

   // Timer step; callers only use it while the count is above one
   function [`EEDR_TMR_W-1:0] tmr_dec;
      input [`EEDR_TMR_W-1:0] t;
      begin
         tmr_dec = t - TMR_ONE;
      end
   endfunction

   // Control write filter: a start bit takes only when its enable was
   // already set, and a forbidden mix keeps only the strongest start
   function [7:0] ctrl_filter;
      input [7:0] w;
      input [7:0] c;
      reg   [7:0] f;
      begin
         f = w;
         f[`EEDR_B_RD_START] = w[`EEDR_B_RD_START] & c[`EEDR_B_RD_EN];
         f[`EEDR_B_WR_START] = w[`EEDR_B_WR_START] & c[`EEDR_B_WR_EN];
         f[`EEDR_B_ER_START] = w[`EEDR_B_ER_START] & c[`EEDR_B_ER_EN];
         // Forbidden combinations: erase beats write beats read
         if (f[`EEDR_B_ER_START]) begin
            f[`EEDR_B_WR_START] = 1'b0;
            f[`EEDR_B_RD_START] = 1'b0;
         end
         if (f[`EEDR_B_WR_START]) begin
            f[`EEDR_B_RD_START] = 1'b0;
         end
         ctrl_filter = f;
      end
   endfunction

   // ----------------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------------
   reg [6:0]             addr_q;
   reg [6:0]             addr_d;
   reg [7:0]             data_q;
   reg [7:0]             data_d;
   reg [7:0]             ctrl_q;
   reg [7:0]             ctrl_d;
   reg [2:0]             state_q;
   reg [2:0]             state_d;
   reg [`EEDR_TMR_W-1:0] tmr_q;
   reg [`EEDR_TMR_W-1:0] tmr_d;
   reg                   erase_q;
   reg                   erase_d;
   reg                   full_q;
   reg                   full_d;
   reg                   done_d;
   reg                   commit;
   reg                   buf_load;
   reg                   buf_clr;
   wire [7:0]            rdata;
   wire                  page_mode;
   wire                  busy;

   assign page_mode = ctrl_q[`EEDR_B_MODE];
   // A start bit stored but not yet taken up counts as busy as well, so
   // no write can move the address under a cycle that is starting
   assign busy = (state_q != ST_IDLE) | ctrl_q[`EEDR_B_ER_START] |
                 ctrl_q[`EEDR_B_WR_START] | ctrl_q[`EEDR_B_RD_START];
   assign o_addr_q  = {1'b0, addr_q};
   assign o_data_q  = data_q;
   assign o_ctrl_q  = ctrl_q;

   // ----------------------------------------------------------------------
   // Array and page buffer
   // ----------------------------------------------------------------------
   eedr_mem u_mem (
      .i_clk      (i_clk),
      .i_reset_n  (i_reset_n),
      .i_addr     (addr_q),
      .i_data     (buf_load ? i_wdata : data_q),
      .i_commit   (commit),
      .i_erase    (erase_q),
      .i_page     (page_mode),
      .i_buf_load (buf_load),
      .i_buf_clr  (buf_clr),
      .o_rdata    (rdata)
   );

   // ----------------------------------------------------------------------
   // Next-state logic
   // ----------------------------------------------------------------------
   always @* begin
      addr_d   = addr_q;
      data_d   = data_q;
      ctrl_d   = ctrl_q;
      state_d  = state_q;
      tmr_d    = tmr_q;
      erase_d  = erase_q;
      full_d   = full_q;
      done_d   = 1'b0;
      commit   = 1'b0;
      buf_load = 1'b0;

      // Register writes are honoured only while idle, since a new start
      // or a moved address mid-cycle would corrupt the running operation
      if (!busy) begin
         if (i_addr_wr) begin
            addr_d = i_wdata[6:0];
            full_d = 1'b0;
         end
         if (i_data_wr) begin
            data_d = i_wdata;
            if (page_mode && !full_q) begin
               buf_load = 1'b1;
               addr_d   = sat_inc(addr_q);
               full_d   = (addr_q[3:0] == `EEDR_OFF_MAX);
            end
         end
         if (i_ctrl_wr) begin
            ctrl_d = ctrl_filter(i_wdata, ctrl_q);
         end
      end

      case (state_q)
         ST_IDLE: begin
            if (ctrl_q[`EEDR_B_ER_START]) begin
               erase_d = 1'b1;
               state_d = ST_PROG;
               tmr_d   = cyc_len(1'b1, ctrl_q[`EEDR_B_CYC_SEL]);
            end else if (ctrl_q[`EEDR_B_WR_START]) begin
               erase_d = 1'b0;
               state_d = ST_PROG;
               tmr_d   = cyc_len(1'b0, ctrl_q[`EEDR_B_CYC_SEL]);
            end else if (ctrl_q[`EEDR_B_RD_START] &&
                         ctrl_q[`EEDR_B_RD_EN]) begin
               state_d = ST_RD;
               tmr_d   = RD_CYC;
            end
         end
         ST_RD: begin
            if (tmr_q == TMR_ONE) begin
               data_d  = rdata;
               state_d = page_mode ? ST_RD_INC : ST_RD_CLR;
            end else begin
               tmr_d = tmr_dec(tmr_q);
            end
         end
         ST_RD_INC: begin
            // Next start reads the following byte, or offset fifteen again, without reloading
            addr_d  = sat_inc(addr_q);
            state_d = ST_RD_CLR;
         end
         ST_RD_CLR: begin
            ctrl_d[`EEDR_B_RD_START] = 1'b0;
            state_d = ST_IDLE;
         end
         ST_PROG: begin
            if (tmr_q == TMR_ONE) begin
               commit  = 1'b1;
               done_d  = 1'b1;
               state_d = ST_EN_CLR;
               if (erase_q) begin
                  ctrl_d[`EEDR_B_ER_START] = 1'b0;
               end else begin
                  ctrl_d[`EEDR_B_WR_START] = 1'b0;
               end
            end else begin
               tmr_d = tmr_dec(tmr_q);
            end
         end
         ST_EN_CLR: begin
            // Erase enable, or write enable in page mode only, drops one cycle after the start bit has cleared
            if (erase_q) begin
               ctrl_d[`EEDR_B_ER_EN] = 1'b0;
            end else if (page_mode) begin
               ctrl_d[`EEDR_B_WR_EN] = 1'b0;
            end
            full_d  = 1'b0;
            state_d = ST_IDLE;
         end
         default: begin
            state_d = ST_IDLE;
         end
      endcase

      // Page buffer empties when either programming enable falls
      buf_clr = (ctrl_q[`EEDR_B_ER_EN] & ~ctrl_d[`EEDR_B_ER_EN]) |
                (ctrl_q[`EEDR_B_WR_EN] & ~ctrl_d[`EEDR_B_WR_EN]);
   end

   // ----------------------------------------------------------------------
   // State registers
   // ----------------------------------------------------------------------
   always @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         addr_q  <= `EEDR_ADDR_RST;
         data_q  <= `EEDR_DATA_RST;
         ctrl_q  <= `EEDR_CTRL_RST;
         state_q <= ST_IDLE;
         tmr_q   <= {`EEDR_TMR_W{1'b0}};
         erase_q <= 1'b0;
         full_q  <= 1'b0;
      end else begin
         addr_q  <= addr_d;
         data_q  <= data_d;
         ctrl_q  <= ctrl_d;
         state_q <= state_d;
         tmr_q   <= tmr_d;
         erase_q <= erase_d;
         full_q  <= full_d;
      end
   end

   // ----------------------------------------------------------------------
   // Completion event
   // ----------------------------------------------------------------------
   // Registered so the event is a clean one-cycle pulse
   always @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_done <= 1'b0;
      end else begin
         o_done <= done_d;
      end
   end

endmodule

// *** common/eedr_regs.vh ***
`ifndef EEDR_REGS_VH
`define EEDR_REGS_VH

// ----------------------------------------------------------------------
// Register widths and reset values
// ----------------------------------------------------------------------
`define EEDR_ADDR_W        7
`define EEDR_DATA_RST      8'h00
`define EEDR_CTRL_RST      8'h00
`define EEDR_ADDR_RST      7'h00

// ----------------------------------------------------------------------
// Control register field positions
// ----------------------------------------------------------------------
`define EEDR_B_CYC_SEL     7
`define EEDR_B_ER_EN       6
`define EEDR_B_ER_START    5
`define EEDR_B_MODE        4
`define EEDR_B_WR_EN       3
`define EEDR_B_WR_START    2
`define EEDR_B_RD_EN       1
`define EEDR_B_RD_START    0

// ----------------------------------------------------------------------
// Address split and page limit
// ----------------------------------------------------------------------
`define EEDR_OFF_W         4
`define EEDR_OFF_MAX       4'h0F
`define EEDR_PAGE_BYTES    16

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define EEDR_CLK_MHZ       20
`define EEDR_T_ER_SHORT_US 3200
`define EEDR_T_ER_LONG_US  3700
`define EEDR_T_WR_SHORT_US 2200
`define EEDR_T_WR_LONG_US  2700
// Cycle counts are the times above at the clock rate, sized to the timer
`define EEDR_ER_SHORT_CYC  18'h0_FA00
`define EEDR_ER_LONG_CYC   18'h1_2110
`define EEDR_WR_SHORT_CYC  18'h0_ABE0
`define EEDR_WR_LONG_CYC   18'h0_D2F0
`define EEDR_RD_CYC        18'h0_0003
`define EEDR_TMR_W         18

`endif

// *** design/eedr_mem.v ***
`timescale 1ns/100ps
`include "eedr_regs.vh"

module eedr_mem (
   // Clock and reset
   input  wire       i_clk,
   input  wire       i_reset_n,
   // Array access
   input  wire [6:0] i_addr,
   input  wire [7:0] i_data,
   input  wire       i_commit,
   input  wire       i_erase,
   input  wire       i_page,
   // Page buffer
   input  wire       i_buf_load,
   input  wire       i_buf_clr,
   // Read port
   output reg  [7:0] o_rdata
);

   // ----------------------------------------------------------------------
   // Storage
   // ----------------------------------------------------------------------
   // The array is not reset: it models non-volatile content
   reg [7:0]  mem_q [0:127];
   reg [7:0]  buf_q [0:`EEDR_PAGE_BYTES-1];
   reg [15:0] tag_q;
   integer    k;

   always @(posedge i_clk) begin
      o_rdata <= mem_q[i_addr];
      if (i_commit && !i_page) begin
         mem_q[i_addr] <= i_erase ? 8'h00 : i_data;
      end
      if (i_commit && i_page) begin
         for (k = 0; k < `EEDR_PAGE_BYTES; k = k + 1) begin
            if (tag_q[k]) begin
               mem_q[{i_addr[6:4], k[3:0]}] <= i_erase ? 8'h00 : buf_q[k];
            end
         end
      end
      if (i_buf_load) begin
         buf_q[i_addr[3:0]] <= i_data;
      end
   end

   // ----------------------------------------------------------------------
   // Page buffer tags
   // ----------------------------------------------------------------------
   always @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         tag_q <= 16'h0000;
      end else begin
         if (i_buf_clr) begin
            tag_q <= 16'h0000;
         end
         // A byte loaded in the clearing cycle keeps its tag
         if (i_buf_load) begin
            tag_q[i_addr[3:0]] <= 1'b1;
         end
      end
   end

endmodule

// *** tb/eedr_ctrl_asserts.sv ***
`timescale 1ns/100ps
module eedr_ctrl_asserts (
   // Clock and reset
   input wire       i_clk,
   input wire       i_reset_n,
   // Register bus
   input wire       i_addr_wr,
   input wire       i_data_wr,
   input wire       i_ctrl_wr,
   input wire [7:0] i_wdata,
   // Register values
   input wire [7:0] o_addr_q,
   input wire [7:0] o_data_q,
   input wire [7:0] o_ctrl_q,
   input wire       o_done
);
   // ----
   // Checks
   // ----
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_reset_n);
   a_addr_top: assert property (
      o_addr_q[7] == 1'b0) else $error("address bit seven set");
   a_start_gate: assert property (
      $rose(o_ctrl_q[0]) |-> $past(o_ctrl_q[1]))
      else $error("read started without enable");
   a_read_ends: assert property (
      $rose(o_ctrl_q[0]) |-> ##[1:8] !o_ctrl_q[0])
      else $error("read start never cleared");
   a_data_hold: assert property (
      $changed(o_data_q) |-> $past(i_data_wr) || $past(o_ctrl_q[0])
         || $past(o_ctrl_q[2]) || $past(o_ctrl_q[5]))
      else $error("data changed without cause");
   a_done_cause: assert property (
      o_done |-> $fell(o_ctrl_q[2]) || $fell(o_ctrl_q[5]))
      else $error("stray done pulse");
   a_write_done: assert property (
      $fell(o_ctrl_q[2]) |-> o_done) else $error("write end no done");
   a_erase_end: assert property (
      $fell(o_ctrl_q[5]) |-> o_done && o_ctrl_q[6] ##1 !o_ctrl_q[6])
      else $error("erase end order wrong");
   a_page_sel: assert property (
      $fell(o_ctrl_q[0]) && o_ctrl_q[4]
         |-> o_addr_q[6:4] == $past(o_addr_q[6:4], 2))
      else $error("page bits moved");
   a_page_step: assert property (
      $fell(o_ctrl_q[0]) && o_ctrl_q[4] |-> o_addr_q[3:0] ==
         ($past(o_addr_q[3:0], 2) == 4'hF ? 4'hF
            : $past(o_addr_q[3:0], 2) + 4'h1))
      else $error("page offset step wrong");
   a_byte_addr: assert property (
      $fell(o_ctrl_q[0]) && !o_ctrl_q[4] |-> $stable(o_addr_q))
      else $error("byte read moved address");
   c_page: cover property ($fell(o_ctrl_q[0]) && o_ctrl_q[4]);
   c_erase: cover property (o_done && $fell(o_ctrl_q[5]));
   c_write: cover property (o_done && $fell(o_ctrl_q[2]));
endmodule
bind eedr_ctrl eedr_ctrl_asserts u_chk (
   .i_clk(i_clk), .i_reset_n(i_reset_n), .i_addr_wr(i_addr_wr),
   .i_data_wr(i_data_wr), .i_ctrl_wr(i_ctrl_wr), .i_wdata(i_wdata),
   .o_addr_q(o_addr_q), .o_data_q(o_data_q), .o_ctrl_q(o_ctrl_q),
   .o_done(o_done));

// *** tb/eedr_core_model.sv ***
`timescale 1ns/100ps
module eedr_core_model (
   // Clock
   input  wire       i_clk,
   // Register writes
   output reg        o_addr_wr,
   output reg        o_data_wr,
   output reg        o_ctrl_wr,
   output reg  [7:0] o_wdata
);
   // ----
   // Software side
   // ----
   initial begin
      {o_addr_wr, o_data_wr, o_ctrl_wr} = 3'b000;
      o_wdata = 8'h00;
   end
   // One register per call, so at most one bit raised per write; the
   // bench waits for erase and write ends, and the clock never stops
   task put(input [1:0] sel, input [7:0] v);
      begin
         @(negedge i_clk);
         o_wdata   <= v;
         o_addr_wr <= (sel == 2'd0);
         o_data_wr <= (sel == 2'd1);
         o_ctrl_wr <= (sel == 2'd2);
         @(negedge i_clk);
         {o_addr_wr, o_data_wr, o_ctrl_wr} <= 3'b000;
         o_wdata <= ~v;
      end
   endtask
endmodule

// *** tb/eedr_ctrl_bench.sv ***
`timescale 1ns/100ps
module eedr_ctrl_bench;
   // ----
   // Signals and model state
   // ----
   logic       i_clk     = 1'b0;
   logic       i_reset_n = 1'b0;
   wire        addr_wr, data_wr, ctrl_wr, o_done;
   wire  [7:0] wdata, o_addr_q, o_data_q, o_ctrl_q;
   integer     bad_count = 0;
   integer     n_checks  = 0;
   integer     seed      = 98471;
   integer     n_done    = 0;
   integer     i, n, t_s, t_l;
   logic [7:0] v;
   logic [6:0] e;
   logic [7:0] mem [0:127];

   eedr_core_model core (.i_clk(i_clk), .o_addr_wr(addr_wr),
      .o_data_wr(data_wr), .o_ctrl_wr(ctrl_wr), .o_wdata(wdata));
   // Short cycle counts keep the run brief
   eedr_ctrl #(.ER_SHORT_CYC(18'd20), .ER_LONG_CYC(18'd25),
      .WR_SHORT_CYC(18'd10), .WR_LONG_CYC(18'd15)) dut (
      .i_clk(i_clk), .i_reset_n(i_reset_n), .i_addr_wr(addr_wr),
      .i_data_wr(data_wr), .i_ctrl_wr(ctrl_wr), .i_wdata(wdata),
      .o_addr_q(o_addr_q), .o_data_q(o_data_q), .o_ctrl_q(o_ctrl_q),
      .o_done(o_done));

   initial forever #25 i_clk = ~i_clk;

   // Each completion pulse spans exactly one falling edge
   always @(negedge i_clk) begin
      if (o_done === 1'b1) begin
         n_done = n_done + 1;
      end
   end

   task report_and_stop;
      begin
         $display("checks %0d mismatches %0d", n_checks, bad_count);
         if (bad_count == 0 && n_checks > 0)
            $display("Finished cleanly");
         else
            $display("Finished with errors");
         $finish;
      end
   endtask

   task chk(input [7:0] got, input [7:0] exp);
      begin
         n_checks = n_checks + 1;
         if (got !== exp) begin
            bad_count = bad_count + 1;
            $display("MISMATCH %0t got %h want %h", $time, got, exp);
         end
      end
   endtask

   // Bounded poll until a start bit self-clears
   task wait_clr(input integer b, output integer c);
      begin
         c = 0;
         while (o_ctrl_q[b] !== 1'b0) begin
            @(negedge i_clk);
            c = c + 1;
            if (c > 2000) begin
               bad_count = bad_count + 1;
               $display("MISMATCH %0t start bit stuck", $time);
               report_and_stop;
            end
         end
      end
   endtask

   task wr_byte(input [6:0] a, input [7:0] d, input s, output integer c);
      begin
         core.put(2'd0, {1'b0, a});
         core.put(2'd1, d);
         core.put(2'd2, {s, 7'h08});
         core.put(2'd2, {s, 7'h0C});
         wait_clr(2, c);
         mem[a] = d;
         chk(o_ctrl_q, {s, 7'h08});
      end
   endtask

   task rd_go(input [7:0] cv, input [6:0] a);
      begin
         core.put(2'd2, cv | 8'h01);
         wait_clr(0, n);
         chk(o_data_q, mem[a]);
      end
   endtask

   // ----
   // Main sequence
   // ----
   initial begin
      repeat (5) @(negedge i_clk);
      i_reset_n = 1'b1;
      chk(o_addr_q, 8'h00);
      chk(o_data_q, 8'h00);
      chk(o_ctrl_q, 8'h00);
      core.put(2'd0, 8'hFF);
      chk(o_addr_q, 8'h7F);
      core.put(2'd1, 8'hA5);
      chk(o_data_q, 8'hA5);
      for (i = 0; i < 4; i = i + 1) begin
         v = $random(seed);
         wr_byte(7'h2C + i[6:0], v, 1'b0, t_s);
      end
      wr_byte(7'h10, 8'h3C, 1'b1, t_l);
      chk(8'(t_l - t_s), 8'h05);
      core.put(2'd2, 8'h00);
      core.put(2'd2, 8'h01);
      repeat (8) @(negedge i_clk);
      chk(o_ctrl_q, 8'h00);
      chk(o_data_q, 8'h3C);
      core.put(2'd2, 8'h02);
      for (i = 3; i >= 0; i = i - 1) begin
         core.put(2'd0, 8'h2C + i[7:0]);
         rd_go(8'h02, 7'h2C + i[6:0]);
         chk(o_addr_q, 8'h2C + i[7:0]);
      end
      core.put(2'd0, 8'h2D);
      core.put(2'd2, 8'h12);
      for (i = 0; i < 4; i = i + 1) begin
         e = (i < 2) ? 7'h2D + i[6:0] : 7'h2F;
         rd_go(8'h12, e);
         e = (i < 2) ? 7'h2E + i[6:0] : 7'h2F;
         chk(o_addr_q, {1'b0, e});
      end
      core.put(2'd0, 8'h2C);
      core.put(2'd2, 8'h40);
      core.put(2'd2, 8'h60);
      wait_clr(5, n);
      chk(o_ctrl_q, 8'h40);
      @(negedge i_clk);
      chk(o_ctrl_q, 8'h00);
      mem[7'h2C] = 8'h00;
      core.put(2'd2, 8'h02);
      rd_go(8'h02, 7'h2C);
      core.put(2'd2, 8'h10);
      core.put(2'd0, 8'h30);
      for (i = 0; i < 2; i = i + 1) begin
         v = $random(seed);
         core.put(2'd1, v);
         mem[7'h30 + i[6:0]] = v;
      end
      chk(o_addr_q, 8'h32);
      core.put(2'd2, 8'h18);
      core.put(2'd2, 8'h1C);
      wait_clr(2, n);
      @(negedge i_clk);
      chk(o_ctrl_q, 8'h10);
      core.put(2'd2, 8'h02);
      for (i = 0; i < 2; i = i + 1) begin
         core.put(2'd0, 8'h30 + i[7:0]);
         rd_go(8'h02, 7'h30 + i[6:0]);
      end
      chk(n_done[7:0], 8'h07);
      report_and_stop;
   end
endmodule
